// ### hdl/spi_xfer_defs.vh
// register offsets, field positions, reset values and counts of the serial transfer engine
`ifndef SPI_XFER_DEFS_VH
`define SPI_XFER_DEFS_VH

// register byte offsets
`define OFF_DATA 8'h00
`define OFF_CTRL 8'h04
`define OFF_STAT 8'h08
`define OFF_IRQ_STAT 8'h0c
`define OFF_IRQ_MASK 8'h10

// control register fields
`define CTRL_EN 0
`define CTRL_ENH 1
`define CTRL_SERIAL_IF_IRQ_ENABLE 2
`define CTRL_SERIAL_PORT_IRQ_ENABLE 3
`define CTRL_DIV_LO 8
`define CTRL_DIV_HI 15
`define CTRL_RESET 32'h0000_0300

// status register fields
`define STAT_DONE 0
`define STAT_WRITE_COLLISION 1
`define STAT_LOAD_WINDOW 2
`define STAT_BUSY 3
`define STAT_SS 4

// interrupt status / mask fields
`define IRQ_DONE 0
`define IRQ_WRITE_COLLISION 1
`define IRQ_BITS 2

// bits per transfer and length of the load window in bit slots
`define BITS_PER_BYTE 4'd8
`define LOAD_WINDOW_SLOTS 4'd4

`endif

// ### hdl/spi_bit_clock.v
// free-running bit slot timer: marks the start and middle of each shift clock bit slot
module spi_bit_clock #(
  parameter DIV_W = 8
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // half slot length minus one, in hclk cycles
  input wire [DIV_W-1:0] half_div,
  // slot marks, one-cycle pulses
  output reg lead_r,
  output reg trail_r
);

  reg [DIV_W-1:0] cnt_r;
  reg phase_r;
  wire tick;

  assign tick = (cnt_r == {DIV_W{1'b0}});

  // the timer never stops, so a new byte waits for the next whole slot to begin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {DIV_W{1'b0}};
      phase_r <= 1'b0;
      lead_r <= 1'b0;
      trail_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= tick ? half_div : cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
      if (tick) begin
        phase_r <= ~phase_r;
      end
      lead_r <= tick & phase_r; // phase going low: slot begins
      trail_r <= tick & ~phase_r; // phase going high: mid slot
    end
  end

endmodule

// ### hdl/spi_master_buffered_write.v
// byte-wide serial master with normal and buffered write modes behind an ahb-lite slave
//
// Function
// - normal write starts clock, shifts byte out
// - first edge waits for next bit slot
// - byte done: stop clock, flag, copy receive
// - interrupt only with both enables set
// - one data address: write path, read buffer
// - normal busy write: collision flag, byte dropped
// - enhanced write loads buffer, sets full flag
// - full flag clears when buffer moves out
// - idle enhanced write starts at once, clears
// - load window flag over first four slots
// - buffered byte follows with no clock stop
// - four pins as alternate port functions
`include "spi_xfer_defs.vh"

module spi_master_buffered_write #(
  parameter DIV_W = 8
) (
  // clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_r,
  output reg hreadyout_r,
  output reg hresp_r,
  // serial link pins
  input wire ss_n,
  input wire miso,
  output reg mosi_r,
  output reg mosi_oe_r,
  output reg sck_r,
  output reg sck_oe_r,
  // interrupt
  output reg irq_r
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg miso_m_r;
  reg miso_s_r;
  reg ss_m_r;
  reg ss_s_r;

  // two flops each; only the second stage is read below
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      ss_m_r <= 1'b1;
      ss_s_r <= 1'b1;
    end else if (ce) begin
      miso_m_r <= miso;
      miso_s_r <= miso_m_r;
      ss_m_r <= ss_n;
      ss_s_r <= ss_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire acc;
  wire rd_acc;

  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;

  // a write is held until its data phase, where hwdata stands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (ce) begin
      wr_pend_r <= acc & hwrite;
      if (acc) begin
        wr_addr_r <= haddr;
      end
    end
  end

  wire wr_data;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_stat;
  wire rd_istat;

  assign wr_data = wr_pend_r & (wr_addr_r == `OFF_DATA);
  assign wr_ctrl = wr_pend_r & (wr_addr_r == `OFF_CTRL);
  assign wr_mask = wr_pend_r & (wr_addr_r == `OFF_IRQ_MASK);
  assign rd_stat = rd_acc & (haddr == `OFF_STAT);
  assign rd_istat = rd_acc & (haddr == `OFF_IRQ_STAT);

  ////////////////////////////////////////////////////////////////////////
  // control and mask registers

  reg [31:0] ctrl_r;
  reg [`IRQ_BITS-1:0] mask_r;
  wire enh;

  assign enh = ctrl_r[`CTRL_ENH];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET;
      mask_r <= {`IRQ_BITS{1'b0}};
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r <= {16'h0000, hwdata[15:8], 4'h0, hwdata[3:0]};
      end
      if (wr_mask) begin
        mask_r <= hwdata[`IRQ_BITS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit slot timer

  wire lead;
  wire trail;

  spi_bit_clock #(
    .DIV_W(DIV_W)
  ) u_bit_clock (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .half_div(ctrl_r[`CTRL_DIV_HI:`CTRL_DIV_LO]),
    .lead_r(lead),
    .trail_r(trail)
  );

  ////////////////////////////////////////////////////////////////////////
  // transfer engine

  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [7:0] shift_r;
  reg [7:0] rx_r;
  reg [7:0] rbuf_r;
  reg [7:0] wbuf_r;
  reg [3:0] bit_r;
  reg done_r;
  reg write_collision_flag_r;
  reg done_ev;
  reg collision_ev;
  wire busy;
  wire last_bit;

  assign busy = (state_r != ST_IDLE);
  assign last_bit = (bit_r == `BITS_PER_BYTE - 4'd1);

  // one process owns the done and collision flags the engine and the cpu both touch, so set beats clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      rx_r <= 8'h00;
      rbuf_r <= 8'h00;
      wbuf_r <= 8'h00;
      bit_r <= 4'h0;
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mosi_r <= 1'b0;
      sck_r <= 1'b0;
      done_ev <= 1'b0;
      collision_ev <= 1'b0;
    end else if (ce) begin
      done_ev <= 1'b0;
      collision_ev <= 1'b0;
      // status read clears the done flag; collision too unless it marks a full buffer
      if (rd_stat) begin
        done_r <= 1'b0;
        if (!enh) begin
          write_collision_flag_r <= 1'b0;
        end
      end
      case (state_r)
        ST_IDLE: begin
          sck_r <= 1'b0;
          if (wr_data) begin
            shift_r <= hwdata[7:0];
            state_r <= ST_WAIT;
            if (enh) begin
              write_collision_flag_r <= 1'b0;
            end
          end
        end
        ST_WAIT: begin
          if (lead) begin
            mosi_r <= shift_r[7];
            bit_r <= 4'h0;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (trail) begin
            sck_r <= 1'b1;
            rx_r <= {rx_r[6:0], miso_s_r};
          end else if (lead) begin
            sck_r <= 1'b0;
            if (!last_bit) begin
              bit_r <= bit_r + 4'd1;
              shift_r <= {shift_r[6:0], 1'b0};
              mosi_r <= shift_r[6];
            end else begin
              rbuf_r <= rx_r;
              done_r <= 1'b1;
              done_ev <= 1'b1;
              bit_r <= 4'h0;
              if (enh && write_collision_flag_r) begin
                shift_r <= wbuf_r;
                mosi_r <= wbuf_r[7];
                write_collision_flag_r <= 1'b0;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // writes during a transfer: dropped in normal mode, buffered in enhanced mode
      if (wr_data && busy) begin
        write_collision_flag_r <= 1'b1;
        collision_ev <= 1'b1;
        if (enh) begin
          wbuf_r <= hwdata[7:0];
        end
      end
    end
  end

  // load window: first four slots of every byte, cpu may then refill the buffer
  wire load_window_flag;

  assign load_window_flag = (state_r == ST_RUN) & (bit_r < `LOAD_WINDOW_SLOTS);

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, read to clear

  reg [`IRQ_BITS-1:0] istat_r;
  wire [`IRQ_BITS-1:0] ev;

  assign ev = {collision_ev, done_ev};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= {`IRQ_BITS{1'b0}};
      irq_r <= 1'b0;
    end else if (ce) begin
      istat_r <= (rd_istat ? {`IRQ_BITS{1'b0}} : istat_r) | ev;
      irq_r <= ctrl_r[`CTRL_SERIAL_IF_IRQ_ENABLE] & ctrl_r[`CTRL_SERIAL_PORT_IRQ_ENABLE] &
        (|(istat_r & mask_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin enables

  // mosi and sck leave general use only while the engine is enabled; miso and ss_n have no enable
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mosi_oe_r <= 1'b0;
      sck_oe_r <= 1'b0;
    end else if (ce) begin
      mosi_oe_r <= ctrl_r[`CTRL_EN];
      sck_oe_r <= ctrl_r[`CTRL_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and response

  reg [31:0] rd_nxt;

  // the data address reads the receive buffer, never the write path
  always @* begin
    case (haddr)
      `OFF_DATA: rd_nxt = {24'h000000, rbuf_r};
      `OFF_CTRL: rd_nxt = ctrl_r;
      `OFF_STAT: rd_nxt = {27'h0000000, ss_s_r, busy, load_window_flag,
        write_collision_flag_r, done_r};
      `OFF_IRQ_STAT: rd_nxt = {30'h00000000, istat_r};
      `OFF_IRQ_MASK: rd_nxt = {30'h00000000, mask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // zero-wait slave: read data is latched at the address edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else if (ce) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if (rd_acc) begin
        hrdata_r <= rd_nxt;
      end
    end
  end

endmodule

// ### verif/spi_xfer_chk.sv
// pin-level assertions for the serial master
module spi_xfer_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus and link pins
  input wire [1:0] htrans,
  input wire hreadyout_r,
  input wire hresp_r,
  input wire mosi_r,
  input wire mosi_oe_r,
  input wire sck_r,
  input wire sck_oe_r,
  input wire irq_r
);
  // half slot for the bench divider of 9
  localparam int HALF = 10;
  logic prev_r;
  int run_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence low_s; !sck_r [*8]; endsequence
  ////////////////////////////////////////
  // cycles spent at the current sck level, minus one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= 1'b0;
      run_r <= 0;
    end else begin
      prev_r <= sck_r;
      run_r <= (sck_r != prev_r) ? 0 : run_r + 1;
    end
  end
  okay_resp_a: assert property (hreadyout_r && !hresp_r)
    else $error("bus answer not ready or not okay");
  oe_pair_a: assert property (mosi_oe_r == sck_oe_r)
    else $error("pin enables differ");
  mosi_hold_a: assert property (sck_r |-> $stable(mosi_r))
    else $error("mosi moved while sck high");
  sck_high_a: assert property ($fell(sck_r) |-> run_r == HALF - 1)
    else $error("sck high phase wrong length");
  sck_lead_a: assert property ($rose(sck_r) |-> run_r >= HALF - 1)
    else $error("sck low phase too short");
  sck_low_a: assert property ($fell(sck_r) |-> low_s)
    else $error("sck low phase cut short");
  irq_quiet_a: assert property ($rose(irq_r) |-> !sck_r)
    else $error("interrupt while sck high");
  irq_drop_a: assert property ($fell(irq_r) |-> $past(htrans[1], 2))
    else $error("interrupt fell without access");
endmodule
bind spi_master_buffered_write spi_xfer_chk chk (.hclk(hclk), .hresetn(hresetn),
  .htrans(htrans), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r), .mosi_r(mosi_r),
  .mosi_oe_r(mosi_oe_r), .sck_r(sck_r), .sck_oe_r(sck_oe_r), .irq_r(irq_r));

// ### verif/spi_slave_model.sv
// far-side serial slave: captures mosi bytes, answers a fixed byte
module spi_slave_model (
  // link pins
  input wire sck,
  input wire mosi,
  output logic miso,
  output logic ss_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx = 8'h00;
  logic [7:0] tx = 8'h5a;
  logic [7:0] got[$];
  int n = 0;
  assign ss_n = 1'b1;
  assign miso = tx[7];
  ////////////////////////////////////////
  // sample on the rising sck edge, msb first
  always @(posedge sck) begin
    rx = {rx[6:0], mosi};
    n = n + 1;
    if (n % 8 == 0) got.push_back(rx);
  end
  // reply rotates, so it is back to its start after each byte; the settle out of
  // reset is not a shift clock fall and must not rotate it
  always @(negedge sck) if (n != 0) tx = {tx[6:0], tx[7]};
endmodule

// ### verif/test_spi_master_buffered_write.sv
// bench for the serial master: bus tasks and scenarios
`include "spi_xfer_defs.vh"
module test_spi_master_buffered_write;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata_r, v;
  logic hreadyout_r, hresp_r, mosi_r, mosi_oe_r, sck_r, sck_oe_r, irq_r, miso, ss_n;
  int fails = 0, samples_checked = 0;
  always #4 hclk = ~hclk;
  spi_master_buffered_write uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_r), .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r),
    .hresp_r(hresp_r), .ss_n(ss_n), .miso(miso), .mosi_r(mosi_r),
    .mosi_oe_r(mosi_oe_r), .sck_r(sck_r), .sck_oe_r(sck_oe_r), .irq_r(irq_r));
  spi_slave_model far (.sck(sck_r), .mosi(mosi_r), .miso(miso), .ss_n(ss_n));
  ////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  // one single-word transfer; read data lands in v
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    v = hrdata_r;
  endtask
  task wait_bytes(input int k);
    for (int i = 0; i < 3000 && far.got.size() < k; i++) @(posedge hclk);
  endtask
  task end_of_test;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_regs;
    chk(mosi_oe_r, 1'b0);
    xfer(0, `OFF_CTRL, 0); chk(v, `CTRL_RESET);
    xfer(0, 8'h20, 0); chk(v, 32'h0);
  endtask
  // normal mode, second write while busy must be dropped
  task t_norm;
    xfer(1, `OFF_IRQ_MASK, 32'h3);
    xfer(1, `OFF_CTRL, 32'h090d);
    xfer(1, `OFF_DATA, 32'ha5);
    xfer(1, `OFF_DATA, 32'h3c);
    // the collision raises irq early; wait for the byte and its done flag instead
    wait_bytes(1);
    repeat (30) @(posedge hclk);
    chk(irq_r, 1'b1);
    chk(sck_oe_r, 1'b1);
    chk({24'h0, far.got[0]}, 32'ha5);
    xfer(0, `OFF_DATA, 0); chk(v, 32'h5a);
    xfer(0, `OFF_STAT, 0); chk(v, 32'h13);
    xfer(0, `OFF_IRQ_STAT, 0); chk(v, 32'h3);
    // irq drops at the edge that ends the clearing read, one edge after its address phase
    @(posedge hclk);
    chk(irq_r, 1'b0);
    chk(far.got.size(), 1);
  endtask
  // one enable off: no interrupt though the event is latched
  task t_mask;
    xfer(1, `OFF_CTRL, 32'h0909);
    xfer(1, `OFF_DATA, 32'h0f);
    wait_bytes(2);
    // done lands half a slot after the last capture; leave room past it
    repeat (30) @(posedge hclk);
    chk(irq_r, 1'b0);
    xfer(0, `OFF_IRQ_STAT, 0); chk(v, 32'h1);
  endtask
  // enhanced mode: idle start, buffer overwrite, seamless follow-on
  task t_enh;
    // only done interrupts here, so irq never rises in the middle of a slot
    xfer(1, `OFF_IRQ_MASK, 32'h1);
    xfer(1, `OFF_CTRL, 32'h090f);
    xfer(1, `OFF_DATA, 32'h11);
    @(posedge hclk);
    xfer(0, `OFF_STAT, 0); chk(v[1], 1'b0);
    for (int i = 0; i < 40 && !(v[2] && !v[1]); i++) xfer(0, `OFF_STAT, 0);
    chk(v[2], 1'b1);
    xfer(1, `OFF_DATA, 32'h22);
    xfer(1, `OFF_DATA, 32'h33);
    @(posedge hclk);
    xfer(0, `OFF_STAT, 0); chk(v[1], 1'b1);
    wait_bytes(4);
    chk({24'h0, far.got[2]}, 32'h11);
    chk({24'h0, far.got[3]}, 32'h33);
    xfer(0, `OFF_STAT, 0); chk(v[1], 1'b0);
  endtask
  ////////////////////////////////////////
  // reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_norm;
    t_mask;
    t_enh;
    end_of_test;
  end
  // watchdog at 12500 cycles, well beyond the under one thousand cycles the run needs
  initial begin
    #100us;
    fails++;
    end_of_test;
  end
endmodule
